// File: tcms_defs.vh
`ifndef TCMS_DEFS_VH
`define TCMS_DEFS_VH

// Register byte offsets on the peripheral bus.
`define TCMS_OFS_MODE_BASE 8'h00
`define TCMS_OFS_CKS_BASE 8'h20
`define TCMS_OFS_STATUS 8'h30
`define TCMS_OFS_STRIDE 8'h04

// Mode register layout and values.
`define TCMS_MODE_RESV_ONES 8'hC0
`define TCMS_MODE_RESET 6'h00
`define TCMS_BIT_BUF_B 5
`define TCMS_BIT_BUF_A 4
`define TCMS_MODE_LSB 0
`define TCMS_MODE_MSB 3
`define TCMS_CKS_RESET 3'h0
`define TCMS_CKS_MSB 2

// Channels that own general registers C and D.
`define TCMS_CD_CHANNELS 5'h19

// Operating mode codes.
`define TCMS_MD_NORMAL 4'h0
`define TCMS_MD_PWM1 4'h2
`define TCMS_MD_PWM2 4'h3
`define TCMS_MD_PHASE1 4'h4
`define TCMS_MD_PHASE2 4'h5
`define TCMS_MD_PHASE3 4'h6
`define TCMS_MD_PHASE4 4'h7
`define TCMS_MD_RSYNC 4'h8
`define TCMS_MD_CPWM_PEAK 4'hD
`define TCMS_MD_CPWM_VALLEY 4'hE
`define TCMS_MD_CPWM_BOTH 4'hF

// Clock select codes, channel 1.
`define TCMS_CK1_DIV1 3'h0
`define TCMS_CK1_DIV4 3'h1
`define TCMS_CK1_DIV16 3'h2
`define TCMS_CK1_DIV64 3'h3
`define TCMS_CK1_EXTA 3'h4
`define TCMS_CK1_EXTB 3'h5
`define TCMS_CK1_DIV256 3'h6
`define TCMS_CK1_CASCADE 3'h7

// Clock select codes, channel 2.
`define TCMS_CK2_DIV1 3'h0
`define TCMS_CK2_DIV4 3'h1
`define TCMS_CK2_DIV16 3'h2
`define TCMS_CK2_DIV64 3'h3
`define TCMS_CK2_EXTA 3'h4
`define TCMS_CK2_EXTB 3'h5
`define TCMS_CK2_EXTC 3'h6
`define TCMS_CK2_DIV1024 3'h7

// Clock select codes, channels 3 and 4.
`define TCMS_CK34_DIV1 3'h0
`define TCMS_CK34_DIV4 3'h1
`define TCMS_CK34_DIV16 3'h2
`define TCMS_CK34_DIV64 3'h3
`define TCMS_CK34_DIV256 3'h4
`define TCMS_CK34_DIV1024 3'h5
`define TCMS_CK34_EXTA 3'h6
`define TCMS_CK34_EXTB 3'h7

// Prescaler divide ratios, as counter terminal masks.
`define TCMS_PRE_MASK4 10'h003
`define TCMS_PRE_MASK16 10'h00F
`define TCMS_PRE_MASK64 10'h03F
`define TCMS_PRE_MASK256 10'h0FF
`define TCMS_PRE_MASK1024 10'h3FF

`endif

// File: tcms_prescaler.v
`timescale 1ns/1ps
`include "tcms_defs.vh"

module tcms_prescaler #(
    parameter PRE_WIDTH = 10
) (
    input wire clk,
    input wire rst,
    output reg tick4,
    output reg tick16,
    output reg tick64,
    output reg tick256,
    output reg tick1024
);

    reg [PRE_WIDTH-1:0] count_reg;
    wire [PRE_WIDTH-1:0] count_next;

    assign count_next = count_reg + {{(PRE_WIDTH-1){1'b0}}, 1'b1};

    // Each tick is a one-cycle pulse when the low bits of the counter wrap.
    always @(posedge clk)
    begin
        if (rst)
        begin
            count_reg <= {PRE_WIDTH{1'b0}};
            tick4 <= 1'b0;
            tick16 <= 1'b0;
            tick64 <= 1'b0;
            tick256 <= 1'b0;
            tick1024 <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick4 <= (count_reg & `TCMS_PRE_MASK4) == `TCMS_PRE_MASK4;
            tick16 <= (count_reg & `TCMS_PRE_MASK16) == `TCMS_PRE_MASK16;
            tick64 <= (count_reg & `TCMS_PRE_MASK64) == `TCMS_PRE_MASK64;
            tick256 <= (count_reg & `TCMS_PRE_MASK256) == `TCMS_PRE_MASK256;
            tick1024 <= (count_reg & `TCMS_PRE_MASK1024) == `TCMS_PRE_MASK1024;
        end
    end

endmodule // tcms_prescaler

// File: tcms_top.v
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "tcms_defs.vh"

// Overview of operation
// - Channel 1 internal rates /4 /16 /64 /256.
// - Channel 1 code 111 cascades channel 2 wrap.
// - Channels 1,2 codes 100/101 pick pins A/B.
// - Phase counting ignores channel 1/2 clock select.
// - Channel 2: /64, pin C, /1024.
// - Channels 3,4 clock table incl. pins A/B.
// - Mode bits 7,6 read one; write one.
// - Buffer B pairs B with D, D silent.
// - Buffer A pairs A with C, C silent.
// - Channels 1,2 buffer bits read zero, fixed.
// - Mode field decode; prohibited codes listed.
// - Codes 1101/1110/1111 complementary PWM transfer points.
// - Channel 3 special modes; channel 4 follows.
module tcms_top #(
    parameter NUM_CH = 5,
    parameter PRE_WIDTH = 10
) (
    input wire CLK_SYS,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire EXT_CLK_PIN_A,
    input wire EXT_CLK_PIN_B,
    input wire EXT_CLK_PIN_C,
    input wire CH2_COUNTER_WRAP,
    output reg [3:0] COUNT_TICK,
    output reg [1:0] PHASE_COUNT_ACTIVE,
    output reg [19:0] MODE_EFFECTIVE,
    output reg [4:0] BUFFER_PAIR_A,
    output reg [4:0] BUFFER_PAIR_B,
    output reg [4:0] GENERAL_REG_C_EVENT_EN,
    output reg [4:0] GENERAL_REG_D_EVENT_EN
);

    reg [5:0] mode_reg [0:4];
    reg [2:0] cks_reg [1:4];
    reg [2:0] ext_sync1_reg;
    reg [2:0] ext_sync2_reg;
    reg [2:0] ext_prev_reg;
    reg map_hit;
    reg [31:0] rd_next;
    reg [3:0] eff_mode [0:4];
    reg [4:0] eff_buf_a;
    reg [4:0] eff_buf_b;
    reg [3:0] tick_next;
    reg ch4_follows;
    wire [2:0] ext_edge;
    wire tick4;
    wire tick16;
    wire tick64;
    wire tick256;
    wire tick1024;
    wire setup_phase;
    wire access_phase;
    integer i;

    // Mode decode, shared by every channel; only channel 3 keeps the
    // reset-synchronous and complementary codes.
    function [3:0] decode_mode;
        input [3:0] md;
        input is_ch3;
        begin
            case (md)
                `TCMS_MD_NORMAL, `TCMS_MD_PWM1, `TCMS_MD_PWM2:
                    decode_mode = md;
                `TCMS_MD_PHASE1, `TCMS_MD_PHASE2, `TCMS_MD_PHASE3, `TCMS_MD_PHASE4:
                    decode_mode = md;
                `TCMS_MD_RSYNC, `TCMS_MD_CPWM_PEAK, `TCMS_MD_CPWM_VALLEY, `TCMS_MD_CPWM_BOTH:
                    decode_mode = is_ch3 ? md : `TCMS_MD_NORMAL;
                default:
                    decode_mode = `TCMS_MD_NORMAL;
            endcase
        end
    endfunction

    function is_phase;
        input [3:0] md;
        begin
            is_phase = (md == `TCMS_MD_PHASE1) || (md == `TCMS_MD_PHASE2) ||
                (md == `TCMS_MD_PHASE3) || (md == `TCMS_MD_PHASE4);
        end
    endfunction

    function is_ch3_special;
        input [3:0] md;
        begin
            is_ch3_special = (md == `TCMS_MD_RSYNC) || (md == `TCMS_MD_CPWM_PEAK) ||
                (md == `TCMS_MD_CPWM_VALLEY) || (md == `TCMS_MD_CPWM_BOTH);
        end
    endfunction

    // Count source for channels 3 and 4.
    function pick_ch34;
        input [2:0] sel;
        input [4:0] pre;
        input [1:0] ext;
        begin
            case (sel)
                `TCMS_CK34_DIV1: pick_ch34 = 1'b1;
                `TCMS_CK34_DIV4: pick_ch34 = pre[0];
                `TCMS_CK34_DIV16: pick_ch34 = pre[1];
                `TCMS_CK34_DIV64: pick_ch34 = pre[2];
                `TCMS_CK34_DIV256: pick_ch34 = pre[3];
                `TCMS_CK34_DIV1024: pick_ch34 = pre[4];
                `TCMS_CK34_EXTA: pick_ch34 = ext[0];
                `TCMS_CK34_EXTB: pick_ch34 = ext[1];
                default: pick_ch34 = 1'b0;
            endcase
        end
    endfunction

    tcms_prescaler #(
        .PRE_WIDTH(PRE_WIDTH)
    ) u_prescaler (
        .clk(CLK_SYS),
        .rst(RESET),
        .tick4(tick4),
        .tick16(tick16),
        .tick64(tick64),
        .tick256(tick256),
        .tick1024(tick1024)
    );

    // External clock pins are synchronised, then counted on rising edges.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_ext
            always @(posedge CLK_SYS)
            begin
                if (RESET)
                begin
                    ext_sync1_reg[g] <= 1'b0;
                    ext_sync2_reg[g] <= 1'b0;
                    ext_prev_reg[g] <= 1'b0;
                end
                else
                begin
                    ext_sync1_reg[g] <= (g == 0) ? EXT_CLK_PIN_A :
                        (g == 1) ? EXT_CLK_PIN_B : EXT_CLK_PIN_C;
                    ext_sync2_reg[g] <= ext_sync1_reg[g];
                    ext_prev_reg[g] <= ext_sync2_reg[g];
                end
            end
            assign ext_edge[g] = ext_sync2_reg[g] & ~ext_prev_reg[g];
        end
    endgenerate

    assign setup_phase = PSEL & ~PENABLE;
    assign access_phase = PSEL & PENABLE;
    assign PREADY = 1'b1;

    // Address decode and read mux; bits 7,6 of a mode register read one.
    always @*
    begin
        map_hit = 1'b0;
        rd_next = 32'h0000_0000;
        for (i = 0; i < NUM_CH; i = i + 1)
        begin
            if (PADDR == `TCMS_OFS_MODE_BASE + i[7:0] * `TCMS_OFS_STRIDE)
            begin
                map_hit = 1'b1;
                rd_next = {24'h00_0000, `TCMS_MODE_RESV_ONES | {2'b00, mode_reg[i]}};
            end
        end
        for (i = 1; i < NUM_CH; i = i + 1)
        begin
            if (PADDR == `TCMS_OFS_CKS_BASE + i[7:0] * `TCMS_OFS_STRIDE)
            begin
                map_hit = 1'b1;
                rd_next = {29'h0000_0000, cks_reg[i]};
            end
        end
        if (PADDR == `TCMS_OFS_STATUS)
        begin
            map_hit = 1'b1;
            rd_next = {24'h00_0000, ch4_follows, PHASE_COUNT_ACTIVE, COUNT_TICK, 1'b0};
        end
    end

    assign PSLVERR = access_phase & ~map_hit;

    // Read data is captured in the setup cycle and held through the access.
    always @(posedge CLK_SYS)
    begin
        if (RESET)
            PRDATA <= 32'h0000_0000;
        else if (setup_phase && !PWRITE)
            PRDATA <= rd_next;
    end

    // Register writes take effect at the access edge.
    always @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            for (i = 0; i < NUM_CH; i = i + 1)
                mode_reg[i] <= `TCMS_MODE_RESET;
            for (i = 1; i < NUM_CH; i = i + 1)
                cks_reg[i] <= `TCMS_CKS_RESET;
        end
        else if (access_phase && PWRITE)
        begin
            for (i = 0; i < NUM_CH; i = i + 1)
            begin
                if (PADDR == `TCMS_OFS_MODE_BASE + i[7:0] * `TCMS_OFS_STRIDE)
                begin
                    // Channels 1 and 2 have no C/D registers; their buffer bits stay zero.
                    if (i == 1 || i == 2)
                        mode_reg[i] <= {2'b00, PWDATA[`TCMS_MODE_MSB:`TCMS_MODE_LSB]};
                    else
                        mode_reg[i] <= PWDATA[`TCMS_BIT_BUF_B:`TCMS_MODE_LSB];
                end
            end
            for (i = 1; i < NUM_CH; i = i + 1)
            begin
                if (PADDR == `TCMS_OFS_CKS_BASE + i[7:0] * `TCMS_OFS_STRIDE)
                    cks_reg[i] <= PWDATA[`TCMS_CKS_MSB:0];
            end
        end
    end

    // Effective modes and buffer pairing; channel 4 copies channel 3 when
    // channel 3 runs a reset-synchronous or complementary mode.
    always @*
    begin
        for (i = 0; i < NUM_CH; i = i + 1)
        begin
            eff_mode[i] = decode_mode(mode_reg[i][`TCMS_MODE_MSB:`TCMS_MODE_LSB], i == 3);
            eff_buf_a[i] = mode_reg[i][`TCMS_BIT_BUF_A];
            eff_buf_b[i] = mode_reg[i][`TCMS_BIT_BUF_B];
        end
        ch4_follows = is_ch3_special(eff_mode[3]);
        if (ch4_follows)
        begin
            eff_mode[4] = eff_mode[3];
            eff_buf_a[4] = eff_buf_a[3];
            eff_buf_b[4] = eff_buf_b[3];
        end
    end

    // Count tick selection per channel.
    always @*
    begin
        tick_next = 4'h0;
        if (!is_phase(eff_mode[1]))
        begin
            case (cks_reg[1])
                `TCMS_CK1_DIV1: tick_next[0] = 1'b1;
                `TCMS_CK1_DIV4: tick_next[0] = tick4;
                `TCMS_CK1_DIV16: tick_next[0] = tick16;
                `TCMS_CK1_DIV64: tick_next[0] = tick64;
                `TCMS_CK1_EXTA: tick_next[0] = ext_edge[0];
                `TCMS_CK1_EXTB: tick_next[0] = ext_edge[1];
                `TCMS_CK1_DIV256: tick_next[0] = tick256;
                `TCMS_CK1_CASCADE: tick_next[0] = CH2_COUNTER_WRAP;
                default: tick_next[0] = 1'b0;
            endcase
        end
        if (!is_phase(eff_mode[2]))
        begin
            case (cks_reg[2])
                `TCMS_CK2_DIV1: tick_next[1] = 1'b1;
                `TCMS_CK2_DIV4: tick_next[1] = tick4;
                `TCMS_CK2_DIV16: tick_next[1] = tick16;
                `TCMS_CK2_DIV64: tick_next[1] = tick64;
                `TCMS_CK2_EXTA: tick_next[1] = ext_edge[0];
                `TCMS_CK2_EXTB: tick_next[1] = ext_edge[1];
                `TCMS_CK2_EXTC: tick_next[1] = ext_edge[2];
                `TCMS_CK2_DIV1024: tick_next[1] = tick1024;
                default: tick_next[1] = 1'b0;
            endcase
        end
        tick_next[2] = pick_ch34(cks_reg[3], {tick1024, tick256, tick64, tick16, tick4},
            ext_edge[1:0]);
        tick_next[3] = pick_ch34(ch4_follows ? cks_reg[3] : cks_reg[4],
            {tick1024, tick256, tick64, tick16, tick4}, ext_edge[1:0]);
    end

    // Registered outputs toward the counters and compare logic.
    always @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            COUNT_TICK <= 4'h0;
            PHASE_COUNT_ACTIVE <= 2'h0;
            MODE_EFFECTIVE <= 20'h0_0000;
            BUFFER_PAIR_A <= 5'h00;
            BUFFER_PAIR_B <= 5'h00;
            GENERAL_REG_C_EVENT_EN <= 5'h00;
            GENERAL_REG_D_EVENT_EN <= 5'h00;
        end
        else
        begin
            COUNT_TICK <= tick_next;
            PHASE_COUNT_ACTIVE <= {is_phase(eff_mode[2]), is_phase(eff_mode[1])};
            MODE_EFFECTIVE <= {eff_mode[4], eff_mode[3], eff_mode[2], eff_mode[1],
                eff_mode[0]};
            BUFFER_PAIR_A <= eff_buf_a;
            BUFFER_PAIR_B <= eff_buf_b;
            // Channels 1 and 2 have no C/D registers, so no events there.
            GENERAL_REG_C_EVENT_EN <= ~eff_buf_a & `TCMS_CD_CHANNELS;
            GENERAL_REG_D_EVENT_EN <= ~eff_buf_b & `TCMS_CD_CHANNELS;
        end
    end

endmodule // tcms_top

// File: tcms_chk.sv
`timescale 1ns/1ps
module tcms_chk #(
    parameter NUM_CH = 5,
    parameter PRE_WIDTH = 10
) (
    input wire CLK_SYS,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] COUNT_TICK,
    input wire [1:0] PHASE_COUNT_ACTIVE,
    input wire [19:0] MODE_EFFECTIVE,
    input wire [4:0] BUFFER_PAIR_A,
    input wire [4:0] BUFFER_PAIR_B,
    input wire [4:0] GENERAL_REG_C_EVENT_EN,
    input wire [4:0] GENERAL_REG_D_EVENT_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    function automatic logic bad(input logic [3:0] m);
        bad = (m == 4'h1) || (m >= 4'h9 && m <= 4'hC);
    endfunction
    function automatic logic spec(input logic [3:0] m);
        spec = (m == 4'h8) || (m >= 4'hD);
    endfunction
    sequence s_phase_held;
        PHASE_COUNT_ACTIVE[0] ##1 PHASE_COUNT_ACTIVE[0];
    endsequence
    sequence s_pwm1_write;
        PSEL && PENABLE && PWRITE && PADDR == 8'h00 && PWDATA[3:0] == 4'h2;
    endsequence
    a_no_bad_code: assert property (!bad(MODE_EFFECTIVE[3:0]) && !bad(MODE_EFFECTIVE[7:4])
        && !bad(MODE_EFFECTIVE[11:8]) && !bad(MODE_EFFECTIVE[15:12])
        && !bad(MODE_EFFECTIVE[19:16])) else $error("prohibited mode code active");
    a_special_ch3_only: assert property (!spec(MODE_EFFECTIVE[3:0])
        && !spec(MODE_EFFECTIVE[7:4]) && !spec(MODE_EFFECTIVE[11:8]))
        else $error("special mode outside channel 3");
    a_ch4_follows_ch3: assert property (spec(MODE_EFFECTIVE[15:12]) |->
        BUFFER_PAIR_A[4] == BUFFER_PAIR_A[3] && BUFFER_PAIR_B[4] == BUFFER_PAIR_B[3]
        && MODE_EFFECTIVE[19:16] == MODE_EFFECTIVE[15:12])
        else $error("channel 4 does not follow channel 3");
    a_buf_a_silent: assert property ((BUFFER_PAIR_A & GENERAL_REG_C_EVENT_EN) == 5'h00)
        else $error("register C active while paired");
    a_buf_b_silent: assert property ((BUFFER_PAIR_B & GENERAL_REG_D_EVENT_EN) == 5'h00)
        else $error("register D active while paired");
    a_ch12_no_buf: assert property ((BUFFER_PAIR_A[2:1] | BUFFER_PAIR_B[2:1]
        | GENERAL_REG_C_EVENT_EN[2:1] | GENERAL_REG_D_EVENT_EN[2:1]) == 2'b00)
        else $error("buffer bits set on channel 1 or 2");
    a_phase_flag_ch1: assert property (PHASE_COUNT_ACTIVE[0] ==
        (MODE_EFFECTIVE[7:6] == 2'b01)) else $error("phase flag disagrees with mode");
    a_phase_no_tick: assert property (s_phase_held |-> !COUNT_TICK[0])
        else $error("channel 1 ticks in phase counting");
    a_mode_write_seen: assert property (s_pwm1_write |-> ##[1:2]
        MODE_EFFECTIVE[3:0] == 4'h2) else $error("mode write not applied");
endmodule // tcms_chk

bind tcms_top tcms_chk #(.NUM_CH(NUM_CH), .PRE_WIDTH(PRE_WIDTH)) tcms_chk_inst (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .COUNT_TICK(COUNT_TICK),
    .PHASE_COUNT_ACTIVE(PHASE_COUNT_ACTIVE), .MODE_EFFECTIVE(MODE_EFFECTIVE),
    .BUFFER_PAIR_A(BUFFER_PAIR_A), .BUFFER_PAIR_B(BUFFER_PAIR_B),
    .GENERAL_REG_C_EVENT_EN(GENERAL_REG_C_EVENT_EN),
    .GENERAL_REG_D_EVENT_EN(GENERAL_REG_D_EVENT_EN));

// File: tcms_top_bench.sv
`timescale 1ns/1ps
module tcms_top_bench;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} tcms_row_t;
    typedef struct packed {logic [7:0] a; logic [2:0] code; int exp;} tcms_cnt_t;
    logic CLK_SYS = 1'b0;
    logic RESET = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic EXT_CLK_PIN_A = 1'b0;
    logic EXT_CLK_PIN_B = 1'b0;
    logic EXT_CLK_PIN_C = 1'b0;
    logic CH2_COUNTER_WRAP = 1'b0;
    logic [7:0] cyc = 8'h00;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR;
    wire [3:0] COUNT_TICK;
    wire [1:0] PHASE_COUNT_ACTIVE;
    wire [19:0] MODE_EFFECTIVE;
    wire [4:0] BUFFER_PAIR_A, BUFFER_PAIR_B, GENERAL_REG_C_EVENT_EN, GENERAL_REG_D_EVENT_EN;
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] r;
    int i, k, m, ch;
    logic sp, bd;
    logic err;
    // Rows: address, write data, expected read-back; mode writes keep bits 7,6 at one.
    tcms_row_t rows [6] = '{'{8'h00, 32'hFF, 32'hFF}, '{8'h04, 32'hFF, 32'hCF},
        '{8'h08, 32'hF0, 32'hC0}, '{8'h10, 32'hE5, 32'hE5}, '{8'h24, 32'hFF, 32'h07},
        '{8'h20, 32'h55, 32'h00}};
    // Pins A, B, C rise every 16, 32, 64 cycles; the wrap pulses every 8 cycles.
    tcms_cnt_t cnts [18] = '{'{8'h24, 3'h1, 256}, '{8'h24, 3'h2, 64}, '{8'h24, 3'h3, 16},
        '{8'h24, 3'h6, 4}, '{8'h24, 3'h7, 128}, '{8'h24, 3'h4, 64}, '{8'h24, 3'h5, 32},
        '{8'h28, 3'h3, 16}, '{8'h28, 3'h7, 1}, '{8'h28, 3'h6, 16}, '{8'h28, 3'h4, 64},
        '{8'h2C, 3'h0, 1024}, '{8'h2C, 3'h3, 16}, '{8'h2C, 3'h4, 4}, '{8'h2C, 3'h5, 1},
        '{8'h2C, 3'h6, 64}, '{8'h2C, 3'h7, 32}, '{8'h30, 3'h4, 4}};

    tcms_top tcms_top_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EXT_CLK_PIN_A(EXT_CLK_PIN_A), .EXT_CLK_PIN_B(EXT_CLK_PIN_B),
        .EXT_CLK_PIN_C(EXT_CLK_PIN_C), .CH2_COUNTER_WRAP(CH2_COUNTER_WRAP),
        .COUNT_TICK(COUNT_TICK), .PHASE_COUNT_ACTIVE(PHASE_COUNT_ACTIVE),
        .MODE_EFFECTIVE(MODE_EFFECTIVE), .BUFFER_PAIR_A(BUFFER_PAIR_A),
        .BUFFER_PAIR_B(BUFFER_PAIR_B), .GENERAL_REG_C_EVENT_EN(GENERAL_REG_C_EVENT_EN),
        .GENERAL_REG_D_EVENT_EN(GENERAL_REG_D_EVENT_EN));

    always #12.5 CLK_SYS = ~CLK_SYS;

    always @(posedge CLK_SYS)
    begin
        cyc <= cyc + 8'h01;
        EXT_CLK_PIN_A <= cyc[3];
        EXT_CLK_PIN_B <= cyc[4];
        EXT_CLK_PIN_C <= cyc[5];
        CH2_COUNTER_WRAP <= (cyc[2:0] == 3'h0);
    end

    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // The request is held until PREADY is seen high at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        @(posedge CLK_SYS);
        while (PREADY !== 1'b1)
            @(posedge CLK_SYS);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task count_ticks(input tcms_cnt_t c);
        int n;
        int b;
        n = 0;
        b = (c.a - 8'h24) >> 2;
        wr(c.a, {29'h0, c.code});
        repeat (8) @(posedge CLK_SYS);
        repeat (1024)
        begin
            @(posedge CLK_SYS);
            if (COUNT_TICK[b] === 1'b1)
                n++;
        end
        check(n, c.exp);
    endtask

    initial
    begin
        repeat (40000) @(posedge CLK_SYS);
        bad_count++;
        end_of_test;
    end

    initial
    begin
        repeat (20) @(posedge CLK_SYS);
        RESET <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        check(GENERAL_REG_C_EVENT_EN, 5'h19);
        check(GENERAL_REG_D_EVENT_EN, 5'h19);
        check(BUFFER_PAIR_A | BUFFER_PAIR_B, 5'h00);
        for (i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0, r);
            check(r, 32'hC0);
        end
        $display("done: reset values");
        for (i = 0; i < 6; i++)
        begin
            wr(rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0, r);
            check(r, rows[i].r);
            check(err, rows[i].a == 8'h20);
        end
        repeat (3) @(posedge CLK_SYS);
        check(BUFFER_PAIR_B[4], 1'b1);
        check(GENERAL_REG_D_EVENT_EN[4], 1'b0);
        check(BUFFER_PAIR_A[1], 1'b0);
        $display("done: register rows");
        for (k = 0; k < 2; k++)
        begin
            for (m = 0; m < 16; m++)
            begin
                ch = 3 * k;
                // Phase counting on channels 0 and 3, and PWM mode 2 on 3, are not for software.
                if ((m >= 4 && m <= 7) || (m == 3 && ch == 3))
                    continue;
                wr(8'(ch * 4), 32'hD0 | m);
                repeat (3) @(posedge CLK_SYS);
                sp = (m == 8) || (m >= 13);
                bd = (m == 1) || (m >= 9 && m <= 12);
                check(MODE_EFFECTIVE[ch*4 +: 4], (bd || (sp && ch != 3)) ? 0 : m);
                check(GENERAL_REG_C_EVENT_EN[ch], 1'b0);
                if (sp && ch == 3)
                    check(BUFFER_PAIR_A[4], 1'b1);
            end
        end
        wr(8'h0C, 32'hC0);
        $display("done: mode codes");
        wr(8'h04, 32'hC4);
        count_ticks('{8'h24, 3'h1, 0});
        check(PHASE_COUNT_ACTIVE[0], 1'b1);
        apb(1'b0, 8'h30, 32'h0, r);
        check(r[6:5], 2'b01);
        wr(8'h04, 32'hC0);
        $display("done: phase counting");
        for (i = 0; i < 18; i++)
            count_ticks(cnts[i]);
        $display("done: clock sources");
        // Channel 3 in complementary mode runs at /1; channel 4 must follow it.
        wr(8'h2C, 32'h0);
        wr(8'h0C, 32'hCD);
        apb(1'b0, 8'h30, 32'h0, r);
        check(r[7], 1'b1);
        count_ticks('{8'h30, 3'h5, 1024});
        wr(8'h0C, 32'hC0);
        $display("done: channel 4 follows");
        RESET <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        RESET <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        check(GENERAL_REG_C_EVENT_EN, 5'h19);
        check(BUFFER_PAIR_B, 5'h00);
        apb(1'b0, 8'h10, 32'h0, r);
        check(r, 32'hC0);
        $display("done: second reset");
        end_of_test;
    end
endmodule // tcms_top_bench
